// file: dct_daisy_chain.sv
// Function
// - Propagation plus sampling term below reference period
// - Sampling term 15.8 or 15.16 periods
// - Seed is 16 times position times ratio
// - Ratio is sample rate over reference rate
// - Only the first alignment event after reset bumps counter
// - Level triggering only via level grid
// - Outgoing chain resynced to reference clock
// - Primary rearm error within two reference cycles
// - Setup warning; both flags clear on read
module dct_daisy_chain
   import dct_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                refTick,
   input  wire logic                swIssuedEvent,
   input  wire logic                preciseEdgePort,
   input  wire logic                syncPortIn,
   input  wire logic                levelGridEvent,
   input  wire logic                levelPlainEvent,
   input  wire dct_pkg::dct_src_t   chainSrc,
   input  wire logic                edgeSel,
   input  wire dct_pkg::dct_arm_t   armMode,
   input  wire logic                captureBegin,
   input  wire logic                resyncEnable,
   input  wire logic                refSyncEnable,
   input  wire logic                alignMode,
   input  wire logic                reducedChannels,
   input  wire logic [POS_W-1:0]    position,
   input  wire logic [RATIO_W-1:0]  refRatio,
   input  wire logic [SKIP_W-1:0]   skipFactor,
   input  wire logic [15:0]         levelExtraL,
   input  wire logic                hostReadFlags,
   output logic                     chainOut,
   output logic                     acqTrigger,
   output logic [TS_W-1:0]          timestamp,
   output logic [15:0]              alignCount,
   output logic                     aligned,
   output logic [OFS_W-1:0]         windowOffset,
   output logic [15:0]              sampTermHundredths,
   output logic                     rearmError,
   output logic                     setupWarning,
   output logic                     levelSrcRejected
);
   import dct_pkg::*;

   logic            srcRaw;
   logic            srcLevel;
   logic            srcEdge;
   logic            srcEvent;
   logic            refPending;
   logic            chainEvent;
   logic [1:0]      rearmCnt;
   logic [3:0]      sinceRef;
   logic [TS_W-1:0] seed;
   dct_state_t      state;

   function automatic logic [TS_W-1:0] calc_seed(input logic [POS_W-1:0] pos,
                                                 input logic [RATIO_W-1:0] ratio);
      logic [TS_W-1:0] prod;
      prod = TS_W'(SEED_FACTOR) * TS_W'(pos) * TS_W'(ratio);
      return prod;
   endfunction : calc_seed

   function automatic logic [OFS_W-1:0] calc_offset(input logic [POS_W-1:0] pos,
                                                    input logic [RATIO_W-1:0] ratio,
                                                    input logic [15:0] extraL,
                                                    input logic [SKIP_W-1:0] skip);
      logic [OFS_W-1:0] num;
      logic [OFS_W-1:0] den;
      num = OFS_W'(ratio) * (OFS_W'(pos) + 32'h1) - OFS_W'(extraL);
      den = (skip == 8'h0) ? 32'h1 : OFS_W'(skip);
      return (pos == 8'h0) ? 32'h0 : num / den;
   endfunction : calc_offset

   always_comb begin
      case (chainSrc)
         SRC_SW_ISSUED_EVENT: srcRaw = swIssuedEvent;
         SRC_PRECISE_EDGE:    srcRaw = preciseEdgePort;
         SRC_SYNC_PORT:       srcRaw = syncPortIn;
         SRC_LEVEL_GRID:      srcRaw = levelGridEvent;
         default:             srcRaw = 1'b0;
      endcase
   end

   dct_edge_sync uSync (
      .clk       (clk),
      .rst_n     (rst_n),
      .sigIn     (srcRaw),
      .fallSel   (edgeSel == EDGE_SEL_FALL),
      .level     (srcLevel),
      .edgePulse (srcEdge)
   );

   // Optional hold of the event until the next reference edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         refPending <= 1'b0;
      end else if (refSyncEnable && srcEdge && !refTick) begin
         refPending <= 1'b1;
      end else if (refTick) begin
         refPending <= 1'b0;
      end
   end

   assign srcEvent = refSyncEnable ? ((refPending | srcEdge) & refTick) : srcEdge;

   // Time since last reference edge, for setup monitoring
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sinceRef <= 4'h0;
      end else if (refTick) begin
         sinceRef <= 4'h0;
      end else if (sinceRef != 4'hf) begin
         sinceRef <= sinceRef + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (armMode == ARM_NOW || captureBegin) begin
                  state <= ST_ARMED;
               end
            end
            ST_ARMED: begin
               if (chainEvent) begin
                  state <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (rearmCnt == REARM_REF_CYC) begin
                  state <= (armMode == ARM_NOW) ? ST_ARMED : ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   assign chainEvent = (state == ST_ARMED) && srcEvent;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rearmCnt <= 2'h0;
      end else if (state != ST_HOLD) begin
         rearmCnt <= 2'h0;
      end else if (refTick && rearmCnt != REARM_REF_CYC) begin
         rearmCnt <= rearmCnt + 2'h1;
      end
   end

   // Outgoing chain pulse on the reference grid
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chainOut   <= 1'b0;
         acqTrigger <= 1'b0;
      end else begin
         chainOut   <= resyncEnable ? (chainEvent & refTick) | (chainEvent & refSyncEnable)
                                    : srcLevel;
         acqTrigger <= chainEvent && !alignMode;
      end
   end

   // Sticky flags; a new event beats a clear by read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rearmError <= 1'b0;
      end else if (state == ST_HOLD && srcEvent && position == 8'h0) begin
         rearmError <= 1'b1;
      end else if (hostReadFlags) begin
         rearmError <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         setupWarning <= 1'b0;
      end else if (srcEdge && position != 8'h0 && (refTick || sinceRef < SETUP_WIN_SAMP)) begin
         setupWarning <= 1'b1;
      end else if (hostReadFlags) begin
         setupWarning <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         levelSrcRejected <= 1'b0;
      end else begin
         levelSrcRejected <= (chainSrc == SRC_LEVEL_PLAIN) && levelPlainEvent;
      end
   end

   assign seed = calc_seed(position, refRatio);

   // Timestamp: first alignment loads seed, then counts per sample
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timestamp <= TS_RESET;
         aligned   <= 1'b0;
      end else if (alignMode && chainEvent && !aligned) begin
         timestamp <= seed;
         aligned   <= 1'b1;
      end else begin
         timestamp <= timestamp + 48'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         alignCount <= ALIGN_CNT_RESET;
      end else if (alignMode && chainEvent && !aligned) begin
         alignCount <= alignCount + 16'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         windowOffset       <= 32'h0;
         sampTermHundredths <= SAMP_TERM_BASE;
      end else begin
         windowOffset <= calc_offset(position, refRatio,
                                     (chainSrc == SRC_LEVEL_GRID) ? levelExtraL : 16'h0,
                                     skipFactor);
         sampTermHundredths <= reducedChannels ? SAMP_TERM_SMALL : SAMP_TERM_BASE;
      end
   end
endmodule : dct_daisy_chain

// file: dct_daisy_chain_checker.sv
module dct_daisy_chain_checker
   import dct_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic              refTick,
   input wire dct_pkg::dct_src_t chainSrc,
   input wire logic              resyncEnable,
   input wire logic              alignMode,
   input wire logic              reducedChannels,
   input wire logic [7:0]        position,
   input wire logic [15:0]       refRatio,
   input wire logic              hostReadFlags,
   input wire logic              chainOut,
   input wire logic              acqTrigger,
   input wire logic [47:0]       timestamp,
   input wire logic [15:0]       alignCount,
   input wire logic              aligned,
   input wire logic [31:0]       windowOffset,
   input wire logic [15:0]       sampTermHundredths,
   input wire logic              rearmError
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence plainHeld;
      chainSrc == SRC_LEVEL_PLAIN [*8];
   endsequence
   sequence alignStep;
      $rose(aligned);
   endsequence
   samp_term_a: assert property ($stable(reducedChannels) |=> sampTermHundredths ==
      ($past(reducedChannels) ? SAMP_TERM_SMALL : SAMP_TERM_BASE)) else $error("sampling term wrong");
   seed_load_a: assert property (alignStep |-> timestamp == SEED_FACTOR * position * refRatio)
      else $error("seed not loaded");
   ts_count_a: assert property (aligned && $past(aligned) |-> timestamp == $past(timestamp) + 48'h1)
      else $error("timestamp not counting");
   align_count_a: assert property (alignStep |-> alignCount == $past(alignCount) + 16'h1)
      else $error("align count step wrong");
   rearm_sticky_a: assert property (rearmError && !hostReadFlags |=> rearmError)
      else $error("rearm error dropped");
   plain_refused_a: assert property (plainHeld |-> !chainOut && !acqTrigger)
      else $error("plain level triggered");
   resync_ref_a: assert property ($past(resyncEnable) && chainOut |-> $past(refTick))
      else $error("chain output off reference");
   align_no_acq_a: assert property (acqTrigger |-> !$past(alignMode))
      else $error("trigger during alignment");
   offset_zero_a: assert property (position == 8'h0 && $stable(position) |=> windowOffset == 32'h0)
      else $error("offset not zero");
endmodule : dct_daisy_chain_checker

bind dct_daisy_chain dct_daisy_chain_checker CHK (.clk, .rst_n, .refTick, .chainSrc, .resyncEnable,
   .alignMode, .reducedChannels, .position, .refRatio, .hostReadFlags, .chainOut, .acqTrigger,
   .timestamp, .alignCount, .aligned, .windowOffset, .sampTermHundredths, .rearmError);

// file: dct_edge_sync.sv
module dct_edge_sync
   import dct_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic sigIn,
   input  wire logic fallSel,
   output logic      level,
   output logic      edgePulse
);
   logic stage1;
   logic stage2;
   logic stage3;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
      end else begin
         stage1 <= sigIn;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   assign level     = stage2;
   assign edgePulse = fallSel ? (stage3 & ~stage2) : (stage2 & ~stage3);
endmodule : dct_edge_sync

// file: dct_pkg.sv
package dct_pkg;
   // Chain source selection
   typedef enum logic [2:0] {
      SRC_SW_ISSUED_EVENT = 3'h0,
      SRC_PRECISE_EDGE    = 3'h1,
      SRC_SYNC_PORT       = 3'h2,
      SRC_LEVEL_GRID      = 3'h3,
      SRC_LEVEL_PLAIN     = 3'h4
   } dct_src_t;

   // Arming strategy
   typedef enum logic {
      ARM_NOW              = 1'b0,
      ARM_ON_CAPTURE_BEGIN = 1'b1
   } dct_arm_t;

   // Edge selection
   localparam logic EDGE_SEL_RISE = 1'b0;
   localparam logic EDGE_SEL_FALL = 1'b1;

   // Chain monitor states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ARMED = 3'b010,
      ST_HOLD  = 3'b100
   } dct_state_t;

   localparam int          POS_W           = 8;
   localparam int          RATIO_W         = 16;
   localparam int          TS_W            = 48;
   localparam int          OFS_W           = 32;
   localparam int          SKIP_W          = 8;
   localparam logic [4:0]  SEED_FACTOR     = 5'h10;
   // Sampling-clock term in hundredths of a sample period
   localparam logic [15:0] SAMP_TERM_BASE  = 16'h062c; // 15.8 samples
   localparam logic [15:0] SAMP_TERM_SMALL = 16'h05ec; // 15.16 samples
   localparam logic [1:0]  REARM_REF_CYC   = 2'h2;
   localparam logic [TS_W-1:0]  TS_RESET   = 48'h0;
   localparam logic [15:0] ALIGN_CNT_RESET = 16'h0;
   localparam logic [3:0]  SETUP_WIN_SAMP  = 4'h2;
endpackage : dct_pkg

// file: dct_upstream_unit.sv
module dct_upstream_unit
   import dct_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic refTick,
   input wire logic fire,
   output logic     chainLine
);
   logic pending;
   // Launches only on a reference edge, high for one reference period
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pending <= 1'b0;
         chainLine <= 1'b0;
      end else if (refTick) begin
         chainLine <= pending;
         pending <= fire;
      end else if (fire) begin
         pending <= 1'b1;
      end
   end
endmodule : dct_upstream_unit

// file: test_daisy_chain_trigger_sync.sv
module test_daisy_chain_trigger_sync;
   timeunit 1ns;
   timeprecision 1ns;
   import dct_pkg::*;
   logic clk = 0, rst_n = 0, refTick = 0, swIssuedEvent = 0, syncPortIn, fire = 0, captureBegin = 0;
   logic resyncEnable = 0, refSyncEnable = 0, alignMode = 0, reducedChannels = 0, hostReadFlags = 0;
   logic levelPlainEvent = 0, chainOut, acqTrigger, aligned, rearmError, setupWarning, levelSrcRejected;
   dct_src_t chainSrc = SRC_SW_ISSUED_EVENT;
   dct_arm_t armMode = ARM_NOW;
   logic [7:0] position = 0, skipFactor = 8'h1;
   logic [15:0] refRatio = 16'h8, levelExtraL = 0, alignCount, sampTermHundredths;
   logic [47:0] timestamp, tsAt;
   logic [31:0] windowOffset;
   int mismatches = 0, n_checks = 0, cyc = 0, nAcq = 0, nOut = 0, phase = 0;
   logic was = 0;

   dct_daisy_chain DUT (.clk, .rst_n, .refTick, .swIssuedEvent, .preciseEdgePort(1'b0), .syncPortIn,
      .levelGridEvent(1'b0), .levelPlainEvent, .chainSrc, .edgeSel(EDGE_SEL_RISE), .armMode,
      .captureBegin, .resyncEnable, .refSyncEnable, .alignMode, .reducedChannels, .position, .refRatio,
      .skipFactor, .levelExtraL, .hostReadFlags, .chainOut, .acqTrigger, .timestamp, .alignCount,
      .aligned, .windowOffset, .sampTermHundredths, .rearmError, .setupWarning, .levelSrcRejected);
   dct_upstream_unit UP (.clk, .rst_n, .refTick, .fire, .chainLine(syncPortIn));

   always #50 clk = ~clk;
   // Reference edge every eight samples, matching refRatio
   always @(negedge clk) begin
      phase = (phase + 1) % 8;
      refTick <= (phase == 0);
      if (aligned === 1'b1 && !was) tsAt = timestamp;
      was = (aligned === 1'b1);
   end
   always @(posedge clk) begin
      cyc++;
      nAcq += (acqTrigger === 1'b1);
      nOut += (chainOut === 1'b1);
      if (cyc == 20000) begin
         mismatches++;
         summarize();
      end
   end

   task chk(string what, logic [47:0] exp, logic [47:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task idle(int n);
      repeat (n) @(negedge clk);
   endtask : idle
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : pulse
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize

   initial begin
      idle(16);
      rst_n = 1;
      idle(2);
      chk("term", 48'h62c, sampTermHundredths);
      chk("count", 48'h0, alignCount);
      reducedChannels = 1;
      idle(3);
      chk("term", 48'h5ec, sampTermHundredths);
      position = 8'h3;
      resyncEnable = 1;
      refSyncEnable = 1;
      alignMode = 1;
      skipFactor = 8'h2;
      pulse(swIssuedEvent);
      idle(30);
      chk("aligned", 48'h1, aligned);
      chk("seed", 48'h180, tsAt);
      chk("count", 48'h1, alignCount);
      chk("offset", 48'h10, windowOffset);
      pulse(swIssuedEvent);
      idle(30);
      chk("count", 48'h1, alignCount);
      chainSrc = SRC_LEVEL_GRID;
      levelExtraL = 16'h4;
      idle(3);
      chk("offset", 48'he, windowOffset);
      chainSrc = SRC_SW_ISSUED_EVENT;
      position = 8'h0;
      alignMode = 0;
      refSyncEnable = 0;
      resyncEnable = 0;
      idle(3);
      chk("offset", 48'h0, windowOffset);
      nAcq = 0;
      pulse(swIssuedEvent);
      idle(30);
      chk("trigger", 48'h1, nAcq);
      pulse(swIssuedEvent);
      idle(3);
      pulse(swIssuedEvent);
      idle(6);
      chk("rearm", 48'h1, rearmError);
      pulse(hostReadFlags);
      idle(2);
      chk("rearm", 48'h0, rearmError);
      // Switch before the hold ends so the module drops back to idle
      armMode = ARM_ON_CAPTURE_BEGIN;
      idle(20);
      position = 8'h1;
      chainSrc = SRC_SYNC_PORT;
      refSyncEnable = 1;
      resyncEnable = 1;
      nAcq = 0;
      nOut = 0;
      pulse(fire);
      idle(40);
      chk("trigger", 48'h0, nAcq);
      pulse(captureBegin);
      pulse(fire);
      idle(40);
      chk("trigger", 48'h1, nAcq);
      chk("chain", 48'h1, nOut);
      chk("setup", 48'h0, setupWarning);
      // Edge landing just after a reference edge
      chainSrc = SRC_SW_ISSUED_EVENT;
      while (refTick !== 1'b1) idle(1);
      idle(6);
      pulse(swIssuedEvent);
      idle(4);
      chk("setup", 48'h1, setupWarning);
      pulse(hostReadFlags);
      idle(10);
      chk("setup", 48'h0, setupWarning);
      chainSrc = SRC_LEVEL_PLAIN;
      nAcq = 0;
      pulse(captureBegin);
      levelPlainEvent = 1;
      idle(20);
      chk("rejected", 48'h1, levelSrcRejected);
      chk("trigger", 48'h0, nAcq);
      levelPlainEvent = 0;
      summarize();
   end
endmodule : test_daisy_chain_trigger_sync
